// ---- rtl/ifs_sequencer.sv ----
// in-application flash sequencer: registers, unlock, operation engine, read blanking
//
// Operation
// - 80h starts program-zone byte program
// - A0h starts data-zone byte program
// - processor held while operation runs
// - page erase clears 512 bytes either zone
// - page erase never touches boot loader area
// - page chosen from high byte, even-aligned pair
// - 82h program-zone page erase, A2h data zone
// - chip erase spares boot area, drops protection
// - protected flash reads return 00h
// - byte 30us, page 10ms, chip 3s maximum
// - read protect finishes within 400us
// - function field selects one of four operations
// - start bit writable only after unlock pattern
// - start bit clears itself on completion
// - zone bit is seventeenth flash address bit
`timescale 1ns/1ps
`include "ifs_map.svh"
module ifs_sequencer #(
    parameter int unsigned PAGE_ERASE_CYC = `IFS_PAGE_ERASE_MS * 1000 * 1000 * `IFS_CLK_MHZ / 1000,
    parameter int unsigned CHIP_ERASE_CYC = `IFS_CHIP_ERASE_S * 1000 * 1000 * `IFS_CLK_MHZ,
    parameter int unsigned PROTECT_CYC    = `IFS_PROTECT_US * `IFS_CLK_MHZ,
    parameter logic [16:0] BOOT_BASE      = `IFS_BOOT_BASE,
    parameter logic [16:0] BOOT_LAST      = `IFS_BOOT_LAST
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [7:0]        sfr_addr,
    input  wire ifs_pkg::ifs_byte_t sfr_wdata,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    output ifs_pkg::ifs_byte_t     sfr_rdata,
    input  wire logic              code_rd,
    input  wire ifs_pkg::ifs_faddr_t code_addr,
    output ifs_pkg::ifs_byte_t     code_rdata,
    output logic                   cpu_hold
);
    import ifs_pkg::*;

    // ------------------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------------------
    // longest times round down; all are exact at 125 MHz
    localparam ifs_count_t BYTE_PROG_CYC = ifs_count_t'(`IFS_BYTE_PROG_US * `IFS_CLK_MHZ);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    ifs_state_t  state_q;        // operation engine
    ifs_unlock_t unlock_q;       // unlock pattern tracker
    logic [3:0]  sysctl_q;       // low bits of system control
    ifs_byte_t   addr_hi_q;      // flash address high register
    ifs_byte_t   addr_lo_q;      // flash address low register
    ifs_byte_t   data_q;         // data staging register
    logic        zone_q;         // zone select of last control write
    ifs_op_t     fct_q;          // function field of last control write
    logic        busy_q;         // start bit, set while running
    ifs_op_t     run_op_q;       // operation captured at start
    ifs_faddr_t  run_base_q;     // first address of the work loop
    ifs_faddr_t  run_last_q;     // last index of the work loop
    ifs_byte_t   run_data_q;     // byte captured at start
    ifs_count_t  run_dur_q;      // longest time of this operation
    ifs_faddr_t  wcnt_q;         // work loop index
    ifs_count_t  timer_q;        // cycles since start
    logic        protect_q;      // read protection active
    logic        blank_q;        // mask the read answer
    ifs_byte_t   sfr_rdata_q;    // registered register read

    ifs_flash_if u_fif (.clk(clk));

    ifs_flash_mem u_mem (
        .fif (u_fif)
    );

    // ------------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------------
    logic wr_sys;
    logic wr_hi;
    logic wr_lo;
    logic wr_data;
    logic wr_ctrl;
    logic start_ok;
    logic done;

    // register writes are refused while an operation runs so captured values stay put
    assign wr_sys  = sfr_wr && !busy_q && (sfr_addr == `IFS_ADDR_SYSTEM_CONTROL);
    assign wr_hi   = sfr_wr && !busy_q && (sfr_addr == `IFS_ADDR_FLASH_ADDR_HIGH);
    assign wr_lo   = sfr_wr && !busy_q && (sfr_addr == `IFS_ADDR_FLASH_ADDR_LOW);
    assign wr_data = sfr_wr && !busy_q && (sfr_addr == `IFS_ADDR_FLASH_DATA);
    assign wr_ctrl = sfr_wr && !busy_q && (sfr_addr == `IFS_ADDR_FLASH_CONTROL);

    // start needs the unlock and the enable that software is expected to set first
    assign start_ok = wr_ctrl && sfr_wdata[`IFS_CTL_START_BIT]
                      && (unlock_q == IFS_UL_ARMED)
                      && sysctl_q[`IFS_SYS_SPE_BIT]
                      && (!sfr_wdata[`IFS_CTL_ZONE_BIT] || sysctl_q[`IFS_SYS_DZE_BIT]);

    // ------------------------------------------------------------------------
    // plain registers
    // ------------------------------------------------------------------------
    // software-owned bytes, kept until rewritten
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sysctl_q  <= 4'h0;
            addr_hi_q <= `IFS_BYTE_ZERO;
            addr_lo_q <= `IFS_BYTE_ZERO;
            data_q    <= `IFS_BYTE_ZERO;
        end
        else
        begin
            if (wr_sys)
            begin
                sysctl_q <= sfr_wdata[`IFS_SYS_KEEP_MSB:0];
            end
            if (wr_hi)
            begin
                addr_hi_q <= sfr_wdata;
            end
            if (wr_lo)
            begin
                addr_lo_q <= sfr_wdata;
            end
            if (wr_data)
            begin
                data_q <= sfr_wdata;
            end
        end
    end

    // zone and function bits store on every control write, start or not
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            zone_q <= 1'b0;
            fct_q  <= IFS_OP_BYTE_PROGRAM;
        end
        else if (wr_ctrl)
        begin
            zone_q <= sfr_wdata[`IFS_CTL_ZONE_BIT];
            fct_q  <= ifs_op_t'(sfr_wdata[`IFS_CTL_FCT_LSB +: 2]);
        end
    end

    // ------------------------------------------------------------------------
    // unlock tracker
    // ------------------------------------------------------------------------
    // the armed state survives the data byte that follows the pattern,
    // and any control write uses it up, so one pattern buys one start
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            unlock_q <= IFS_UL_IDLE;
        end
        else if (wr_ctrl)
        begin
            unlock_q <= IFS_UL_IDLE;
        end
        else if (wr_data)
        begin
            case (unlock_q)
                IFS_UL_IDLE:
                    unlock_q <= (sfr_wdata == `IFS_UNLOCK_FIRST) ? IFS_UL_GOT1 : IFS_UL_IDLE;
                IFS_UL_GOT1:
                begin
                    if (sfr_wdata == `IFS_UNLOCK_SECOND)
                        unlock_q <= IFS_UL_GOT2;
                    else if (sfr_wdata == `IFS_UNLOCK_FIRST)
                        unlock_q <= IFS_UL_GOT1;   // a fresh first byte restarts
                    else
                        unlock_q <= IFS_UL_IDLE;
                end
                IFS_UL_GOT2:
                    unlock_q <= (sfr_wdata == `IFS_UNLOCK_FIRST) ? IFS_UL_ARMED : IFS_UL_IDLE;
                IFS_UL_ARMED:
                    unlock_q <= IFS_UL_ARMED;      // staged data byte keeps the arm
                default:
                    unlock_q <= IFS_UL_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // operation capture
    // ------------------------------------------------------------------------
    // loop range and longest time are fixed at start and held to the end
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            run_op_q   <= IFS_OP_BYTE_PROGRAM;
            run_base_q <= `IFS_ADDR_ZERO;
            run_last_q <= `IFS_ADDR_ZERO;
            run_data_q <= `IFS_BYTE_ZERO;
            run_dur_q  <= BYTE_PROG_CYC;
        end
        else if (start_ok)
        begin
            run_op_q   <= ifs_op_t'(sfr_wdata[`IFS_CTL_FCT_LSB +: 2]);
            run_data_q <= data_q;
            case (ifs_op_t'(sfr_wdata[`IFS_CTL_FCT_LSB +: 2]))
                IFS_OP_BYTE_PROGRAM:
                begin
                    // zone bit on top of the sixteen address bits
                    run_base_q <= {sfr_wdata[`IFS_CTL_ZONE_BIT], addr_hi_q, addr_lo_q};
                    run_last_q <= `IFS_ADDR_ZERO;
                    run_dur_q  <= BYTE_PROG_CYC;
                end
                IFS_OP_PAGE_ERASE:
                begin
                    // odd high byte folds down onto the even page start; low byte ignored
                    run_base_q <= {sfr_wdata[`IFS_CTL_ZONE_BIT], addr_hi_q[7:1], 1'b0, `IFS_BYTE_ZERO};
                    run_last_q <= `IFS_PAGE_LAST;
                    run_dur_q  <= ifs_count_t'(PAGE_ERASE_CYC);
                end
                IFS_OP_CHIP_ERASE:
                begin
                    run_base_q <= `IFS_ADDR_ZERO;
                    run_last_q <= `IFS_CHIP_LAST;
                    run_dur_q  <= ifs_count_t'(CHIP_ERASE_CYC);
                end
                default:
                begin
                    // read protect touches no cell
                    run_base_q <= `IFS_ADDR_ZERO;
                    run_last_q <= `IFS_ADDR_ZERO;
                    run_dur_q  <= ifs_count_t'(PROTECT_CYC);
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // operation engine
    // ------------------------------------------------------------------------
    ifs_faddr_t cur_addr;
    logic       in_boot;
    logic       work_last;

    assign cur_addr  = run_base_q + wcnt_q;
    assign in_boot   = (cur_addr >= BOOT_BASE) && (cur_addr <= BOOT_LAST);
    assign work_last = (wcnt_q == run_last_q);
    // the timer pads each operation out to its full longest time
    assign done      = (state_q == IFS_ST_WAIT) && (timer_q >= (run_dur_q - ifs_count_t'(1)));

    // idle -> work loop over the cells -> wait out the time -> idle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= IFS_ST_IDLE;
            wcnt_q  <= `IFS_ADDR_ZERO;
        end
        else
        begin
            case (state_q)
                IFS_ST_IDLE:
                begin
                    wcnt_q <= `IFS_ADDR_ZERO;
                    if (start_ok)
                        state_q <= IFS_ST_WORK;
                end
                IFS_ST_WORK:
                begin
                    if (work_last || run_op_q == IFS_OP_READ_PROTECT)
                        state_q <= IFS_ST_WAIT;
                    else
                        wcnt_q <= wcnt_q + 17'h00001;
                end
                IFS_ST_WAIT:
                begin
                    if (done)
                        state_q <= IFS_ST_IDLE;
                end
                default:
                    state_q <= IFS_ST_IDLE;
            endcase
        end
    end

    // cycle timer counts from the start write
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            timer_q <= '0;
        else if (state_q == IFS_ST_IDLE)
            timer_q <= '0;
        else
            timer_q <= timer_q + ifs_count_t'(1);
    end

    // start bit: set on an accepted start, cleared by completion
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            busy_q <= 1'b0;
        else if (start_ok)
            busy_q <= 1'b1;
        else if (done)
            busy_q <= 1'b0;
    end

    // protection: set by its own operation, lifted only by chip erase
    // limitation: held in a flop, so a reset also lifts it
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            protect_q <= 1'b0;
        else if (done && run_op_q == IFS_OP_READ_PROTECT)
            protect_q <= 1'b1;
        else if (done && run_op_q == IFS_OP_CHIP_ERASE)
            protect_q <= 1'b0;
    end

    // processor fetch stays frozen for the whole operation
    assign cpu_hold = busy_q;

    // ------------------------------------------------------------------------
    // flash array drive
    // ------------------------------------------------------------------------
    // erase loops skip every boot loader cell; a byte program may go anywhere
    assign u_fif.we    = (state_q == IFS_ST_WORK) && (run_op_q != IFS_OP_READ_PROTECT)
                         && ((run_op_q == IFS_OP_BYTE_PROGRAM) || !in_boot);
    assign u_fif.waddr = cur_addr;
    assign u_fif.wdata = (run_op_q == IFS_OP_BYTE_PROGRAM) ? run_data_q : `IFS_ERASED_BYTE;
    // the processor is held while busy, so reads never meet a write
    assign u_fif.re    = code_rd;
    assign u_fif.raddr = code_addr;

    // blanking decided with the strobe, applied to the registered answer
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            blank_q <= 1'b0;
        else if (code_rd)
            blank_q <= protect_q;
    end

    assign code_rdata = blank_q ? `IFS_BYTE_ZERO : u_fif.rdata;

    // ------------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------------
    // unused and unmapped bits read zero
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            sfr_rdata_q <= `IFS_BYTE_ZERO;
        else if (sfr_rd)
        begin
            case (sfr_addr)
                `IFS_ADDR_SYSTEM_CONTROL:  sfr_rdata_q <= {4'h0, sysctl_q};
                `IFS_ADDR_FLASH_ADDR_HIGH: sfr_rdata_q <= addr_hi_q;
                `IFS_ADDR_FLASH_ADDR_LOW:  sfr_rdata_q <= addr_lo_q;
                `IFS_ADDR_FLASH_DATA:      sfr_rdata_q <= data_q;
                `IFS_ADDR_FLASH_CONTROL:   sfr_rdata_q <= {busy_q, 1'b0, zone_q, 3'h0, fct_q};
                default:                   sfr_rdata_q <= `IFS_BYTE_ZERO;
            endcase
        end
    end

    assign sfr_rdata = sfr_rdata_q;
endmodule : ifs_sequencer

// ---- rtl/ifs_map.svh ----
// register addresses, field positions, codes and timing figures of the flash sequencer
`ifndef IFS_MAP_SVH
`define IFS_MAP_SVH

// ----------------------------------------------------------------------------
// special function register addresses
// ----------------------------------------------------------------------------
`define IFS_ADDR_SYSTEM_CONTROL  8'hbf
`define IFS_ADDR_FLASH_ADDR_HIGH 8'hf4
`define IFS_ADDR_FLASH_ADDR_LOW  8'hf5
`define IFS_ADDR_FLASH_DATA      8'hf6
`define IFS_ADDR_FLASH_CONTROL   8'hf7

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define IFS_CTL_START_BIT        7
`define IFS_CTL_ZONE_BIT         5
`define IFS_CTL_FCT_LSB          0
`define IFS_SYS_DZE_BIT          3
`define IFS_SYS_SPE_BIT          2
`define IFS_SYS_KEEP_MSB         3

// ----------------------------------------------------------------------------
// reset values and data codes
// ----------------------------------------------------------------------------
`define IFS_BYTE_ZERO            8'h00
`define IFS_ERASED_BYTE          8'hff
`define IFS_UNLOCK_FIRST         8'h55
`define IFS_UNLOCK_SECOND        8'haa
`define IFS_PAGE_LAST            17'h001ff
`define IFS_CHIP_LAST            17'h1ffff
`define IFS_ADDR_ZERO            17'h00000

// ----------------------------------------------------------------------------
// boot loader window (default placement, override by parameter)
// ----------------------------------------------------------------------------
`define IFS_BOOT_BASE            17'h0f000
`define IFS_BOOT_LAST            17'h0ffff

// ----------------------------------------------------------------------------
// longest operation times and clock rate
// ----------------------------------------------------------------------------
`define IFS_CLK_MHZ              125
`define IFS_BYTE_PROG_US         30
`define IFS_PAGE_ERASE_MS        10
`define IFS_CHIP_ERASE_S         3
`define IFS_PROTECT_US           400

`endif

// ---- rtl/ifs_pkg.sv ----
// types shared by the flash sequencer and its flash array
package ifs_pkg;

    // ------------------------------------------------------------------------
    // data and address types
    // ------------------------------------------------------------------------
    typedef logic [7:0]  ifs_byte_t;   // one flash or register byte
    typedef logic [16:0] ifs_faddr_t;  // zone bit plus sixteen address bits
    typedef logic [31:0] ifs_count_t;  // cycle timer

    // ------------------------------------------------------------------------
    // operation selected by the function field
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        IFS_OP_BYTE_PROGRAM = 2'h0,
        IFS_OP_READ_PROTECT = 2'h1,
        IFS_OP_PAGE_ERASE   = 2'h2,
        IFS_OP_CHIP_ERASE   = 2'h3
    } ifs_op_t;

    // ------------------------------------------------------------------------
    // sequencer and unlock states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        IFS_ST_IDLE,
        IFS_ST_WORK,
        IFS_ST_WAIT
    } ifs_state_t;

    typedef enum logic [1:0] {
        IFS_UL_IDLE,
        IFS_UL_GOT1,
        IFS_UL_GOT2,
        IFS_UL_ARMED
    } ifs_unlock_t;

endpackage : ifs_pkg

// ---- rtl/ifs_flash_if.sv ----
// interface between the sequencer and the flash array
`timescale 1ns/1ps
interface ifs_flash_if
    import ifs_pkg::*;
(
    input wire logic clk
);
    logic       we;     // write one byte this cycle
    ifs_faddr_t waddr;  // write address
    ifs_byte_t  wdata;  // write data
    logic       re;     // read strobe
    ifs_faddr_t raddr;  // read address
    ifs_byte_t  rdata;  // read data, the cycle after re

    modport seq (output we, waddr, wdata, re, raddr, input rdata, clk);
    modport mem (input we, waddr, wdata, re, raddr, clk, output rdata);
endinterface : ifs_flash_if

// ---- rtl/ifs_flash_mem.sv ----
// byte-wide flash array model with a registered read port
`timescale 1ns/1ps
`include "ifs_map.svh"
module ifs_flash_mem
    import ifs_pkg::*;
(
    ifs_flash_if.mem fif
);
    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    ifs_byte_t mem_q [0:`IFS_CHIP_LAST];  // both zones, zone bit on top
    ifs_byte_t rdata_q;                   // registered read data

    // write port: erase and program both land here
    always_ff @(posedge fif.clk)
    begin
        if (fif.we)
        begin
            mem_q[fif.waddr] <= fif.wdata;
        end
    end

    // read port: data stand in the cycle after the strobe
    always_ff @(posedge fif.clk)
    begin
        if (fif.re)
        begin
            rdata_q <= mem_q[fif.raddr];
        end
    end

    assign fif.rdata = rdata_q;
endmodule : ifs_flash_mem

// ---- test/ifs_checker.sv ----
// port checker for the flash sequencer, bound to its top module
`timescale 1ns/1ps
`include "ifs_map.svh"
module ifs_checker #(
    parameter int unsigned PAGE_ERASE_CYC = 600,
    parameter int unsigned CHIP_ERASE_CYC = 131080,
    parameter int unsigned PROTECT_CYC    = 50
) (
    input wire logic                clk, reset, sfr_wr, sfr_rd, code_rd, cpu_hold,
    input wire logic [7:0]          sfr_addr,
    input wire ifs_pkg::ifs_byte_t  sfr_wdata, sfr_rdata, code_rdata,
    input wire ifs_pkg::ifs_faddr_t code_addr
);
    import ifs_pkg::*;
    logic [1:0] ul_q;   // unlock progress, 3 means armed
    logic [3:0] sys_q;  // enable bits last written
    logic [2:0] ctl_q;  // zone and function last written
    logic       prot_q; // fetches must read blank
    ifs_count_t cnt_q;  // cycles the hold has stood so far
    wire w7 = sfr_wr && sfr_addr == 8'hf7 && !cpu_hold;
    wire go = w7 && sfr_wdata[7] && ul_q == 2'h3 && sys_q[2] && (!sfr_wdata[5] || sys_q[3]);
    // unlock tracker: a wrong byte drops back, a stray 55 restarts
    always_ff @(posedge clk or posedge reset)
        if (reset)
            ul_q <= 2'h0;
        else if (w7)
            ul_q <= 2'h0;
        else if (sfr_wr && sfr_addr == 8'hf6 && !cpu_hold && ul_q != 2'h3)
            ul_q <= (sfr_wdata == (ul_q[0] ? 8'haa : 8'h55)) ? ul_q + 2'h1 : {1'b0, sfr_wdata == 8'h55};
    // mirrors of the enable and control fields
    always_ff @(posedge clk or posedge reset)
        if (reset)
            {sys_q, ctl_q} <= 7'h00;
        else if (sfr_wr && sfr_addr == 8'hbf && !cpu_hold)
            sys_q <= sfr_wdata[3:0];
        else if (w7)
            ctl_q <= {sfr_wdata[5], sfr_wdata[1:0]};
    // hold length counter, and blanking set by protect, dropped by chip erase
    always_ff @(posedge clk or posedge reset)
        if (reset)
            {prot_q, cnt_q} <= '0;
        else
            {prot_q, cnt_q} <= {(cnt_q != 0 && !cpu_hold && ctl_q[0]) ? !ctl_q[1] : prot_q,
                                cpu_hold ? cnt_q + 32'h1 : 32'h0};
    function automatic ifs_count_t dur(input logic [1:0] op);
        dur = op == 2'h0 ? `IFS_BYTE_PROG_US * `IFS_CLK_MHZ : op == 2'h1 ? PROTECT_CYC :
              op == 2'h2 ? PAGE_ERASE_CYC : CHIP_ERASE_CYC;
    endfunction : dur
    sequence s_run;
        go ##1 cpu_hold;
    endsequence
    sequence s_done;
        cpu_hold ##1 !cpu_hold;
    endsequence
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_start_hold: assert property (go |-> s_run) else $error("no hold after start");
    chk_lock_start: assert property (w7 && sfr_wdata[7] && ul_q != 2'h3 |=> !cpu_hold) else $error("locked start");
    chk_hold_length: assert property (s_done |-> cnt_q == dur(ctl_q[1:0])) else $error("bad hold length");
    chk_hold_cause: assert property ($rose(cpu_hold) |-> $past(go)) else $error("hold without start");
    chk_busy_flag: assert property (cpu_hold && sfr_rd && sfr_addr == 8'hf7 |=> sfr_rdata[7]) else $error("busy low");
    chk_done_clear: assert property (!cpu_hold && sfr_rd && sfr_addr == 8'hf7 |=> !sfr_rdata[7]) else $error("start stuck");
    chk_ctl_fields: assert property (sfr_rd && sfr_addr == 8'hf7 |=> {sfr_rdata[5], sfr_rdata[1:0]} == ctl_q)
        else $error("control fields wrong");
    chk_blank_read: assert property (code_rd && prot_q |=> code_rdata == 8'h00) else $error("protected read");
endmodule : ifs_checker
bind ifs_sequencer ifs_checker #(.PAGE_ERASE_CYC(PAGE_ERASE_CYC), .CHIP_ERASE_CYC(CHIP_ERASE_CYC),
    .PROTECT_CYC(PROTECT_CYC)) chk (.clk, .reset, .sfr_wr, .sfr_rd, .code_rd, .cpu_hold, .sfr_addr,
    .sfr_wdata, .sfr_rdata, .code_rdata, .code_addr);

// ---- test/ifs_cpu_model.sv ----
// processor-side model: register writes, register reads and flash fetches
`timescale 1ns/1ps
module ifs_cpu_model (
    input  wire logic                clk,
    output logic [7:0]               sfr_addr,
    output ifs_pkg::ifs_byte_t       sfr_wdata,
    output logic                     sfr_wr, sfr_rd, code_rd,
    output ifs_pkg::ifs_faddr_t      code_addr,
    input  wire ifs_pkg::ifs_byte_t  sfr_rdata, code_rdata
);
    import ifs_pkg::*;
    initial {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, code_rd, code_addr} = '0;
    // released lines carry the inverse so stale data never looks valid
    task automatic wr(input logic [7:0] a, input ifs_byte_t d);
        @(posedge clk);
        {sfr_addr, sfr_wdata, sfr_wr} <= {a, d, 1'b1};
        @(posedge clk);
        {sfr_wdata, sfr_wr} <= {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output ifs_byte_t d);
        @(posedge clk);
        {sfr_addr, sfr_rd} <= {a, 1'b1};
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask : rd
    task automatic fetch(input ifs_faddr_t a, output ifs_byte_t d);
        @(posedge clk);
        {code_addr, code_rd} <= {a, 1'b1};
        @(posedge clk);
        {code_addr, code_rd} <= {~a, 1'b0};
        #1 d = code_rdata;
    endtask : fetch
    // full software sequence: unlock, enables, address, data, control
    task automatic op(input ifs_byte_t sys, hi, lo, d, ctl);
        wr(8'hf6, 8'h55);
        wr(8'hf6, 8'haa);
        wr(8'hf6, 8'h55);
        wr(8'hbf, sys);
        wr(8'hf4, hi);
        wr(8'hf5, lo);
        wr(8'hf6, d);
        wr(8'hf7, ctl);
    endtask : op
endmodule : ifs_cpu_model

// ---- test/in_app_flash_sequencer_tb_top.sv ----
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
`include "ifs_map.svh"
module in_app_flash_sequencer_tb_top;
    import ifs_pkg::*;
    localparam int unsigned BYTE_CYC = `IFS_BYTE_PROG_US * `IFS_CLK_MHZ;
    logic       clk = 1'b0, reset = 1'b1, sfr_wr, sfr_rd, code_rd, cpu_hold;
    logic [7:0] sfr_addr;
    ifs_byte_t  sfr_wdata, sfr_rdata, code_rdata, got;
    ifs_faddr_t code_addr;
    int         err_count = 0, cmp_count = 0;
    always #4 clk = ~clk; // 125 MHz
    // short erase counts keep the run brief; the chip erase still sweeps all 128K
    ifs_sequencer #(.PAGE_ERASE_CYC(600), .CHIP_ERASE_CYC(131080), .PROTECT_CYC(50)) uut (.clk, .reset,
        .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .code_rd, .code_addr, .code_rdata, .cpu_hold);
    ifs_cpu_model cpu (.clk, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .code_rd, .code_addr, .sfr_rdata,
        .code_rdata);
    task automatic cmp_byte(input string n, input ifs_byte_t e, g);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_byte
    task automatic tally_and_finish;
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // one operation; len is the hold in cycles plus two, zero when refused; the negedge count lags by one
    task automatic go(input ifs_byte_t sys, hi, lo, d, ctl, input int len);
        int n;
        n = 0;
        cpu.op(sys, hi, lo, d, ctl);
        cpu.rd(8'hf7, got);
        cmp_byte("control busy", len != 0 ? ctl : ctl & 8'h7f, got);
        while (cpu_hold !== 1'b0 && n < 200000)
        begin
            @(negedge clk);
            n++;
        end
        cmp_count++;
        if (n != (len != 0 ? len - 3 : 0))
        begin
            err_count++;
            $display("MISMATCH hold expected %0d seen %0d", len != 0 ? len - 3 : 0, n);
        end
        cpu.rd(8'hf7, got);
        cmp_byte("control done", ctl & 8'h7f, got);
    endtask : go
    task automatic mem(input ifs_faddr_t a, input ifs_byte_t e);
        cpu.fetch(a, got);
        cmp_byte("flash", e, got);
    endtask : mem
    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        cpu.rd(8'hf7, got);
        cmp_byte("control reset", 8'h00, got);
        cpu.rd(8'h80, got);
        cmp_byte("unmapped", 8'h00, got);
        cpu.wr(8'hbf, 8'h04);
        cpu.wr(8'hf7, 8'h83);
        cpu.rd(8'hf7, got);
        cmp_byte("locked start", 8'h03, got);
        go(8'h04, 8'h12, 8'h34, 8'ha5, 8'h80, BYTE_CYC + 2);
        go(8'h04, 8'h12, 8'h34, 8'h5a, 8'ha0, 0);
        go(8'h0c, 8'h12, 8'h34, 8'h5a, 8'ha0, BYTE_CYC + 2);
        go(8'h04, 8'h34, 8'h00, 8'h33, 8'h80, BYTE_CYC + 2);
        go(8'h04, 8'hf0, 8'h00, 8'h77, 8'h80, BYTE_CYC + 2);
        go(8'h04, 8'h33, 8'h00, 8'h00, 8'h82, 602);
        go(8'h0c, 8'h12, 8'h00, 8'h00, 8'ha2, 602);
        go(8'h04, 8'hf0, 8'h00, 8'h00, 8'h82, 602);
        mem(17'h01234, 8'ha5);
        mem(17'h11234, 8'hff);
        mem(17'h03200, 8'hff);
        mem(17'h033ff, 8'hff);
        mem(17'h03400, 8'h33);
        mem(17'h0f000, 8'h77);
        go(8'h04, 8'h00, 8'h00, 8'h00, 8'h81, 52);
        mem(17'h03400, 8'h00);
        go(8'h04, 8'h00, 8'h00, 8'h00, 8'h83, 131082);
        mem(17'h03400, 8'hff);
        mem(17'h0f000, 8'h77);
        tally_and_finish();
    end
    // watchdog sized well past the longest expected run
    initial
    begin
        #2500000;
        err_count++;
        tally_and_finish();
    end
endmodule : in_app_flash_sequencer_tb_top
